/* bench/quad_pins_model.sv */
/* Two-phase encoder model driving the channel 2 clock pins.
   Assumes one-cycle step requests on sys_clk from the bench. */
`timescale 1ns/1ps
module quad_pins_model (
    input  wire logic sys_clk,
    input  wire logic stepUp,
    input  wire logic stepDown,
    output logic      pinA,
    output logic      pinB
);
    logic [1:0] phase = 2'h0;
    // One pin edge per step, either direction
    always_ff @(posedge sys_clk) begin
        if (stepUp) begin
            phase <= phase + 2'h1;
        end else if (stepDown) begin
            phase <= phase - 2'h1;
        end
    end
    // Up order on {A,B}: 00 10 11 01; Gray, so pins never move together
    assign pinA = phase[1] ^ phase[0];
    assign pinB = phase[1];
endmodule : quad_pins_model

/* bench/timer_mode_match_checker.sv */
/* Checker for bus handshake, PWM pins, interrupts and standby.
   Bound to timer_mode_match; watches only its ports. */
`timescale 1ns/1ps
module timer_mode_match_checker (
    input wire logic        sys_clk,
    input wire logic        srst,
    input wire logic        standby,
    input wire logic        arvalid,
    input wire logic        arready,
    input wire logic        rvalid,
    input wire logic        rready,
    input wire logic [31:0] rdata,
    input wire logic        bvalid,
    input wire logic        bready,
    input wire logic [1:0]  bresp,
    input wire logic [2:0]  compareMatchA,
    input wire logic [2:0]  compareMatchB,
    input wire logic [2:0]  pwmPinOut,
    input wire logic [2:0]  pwmPinOe_n,
    input wire logic [2:0]  matchAIrq,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Answers stand until taken; no new read while one waits
    a_read_answer: assert property (arvalid && arready |=> rvalid)
        else $error("read not answered");
    a_read_hold: assert property (rvalid && !rready |=> $stable(rdata))
        else $error("read data moved");
    a_write_hold: assert property (bvalid && !bready
        |=> bvalid && $stable(bresp))
        else $error("write answer dropped");
    a_read_refuse: assert property (rvalid |-> !arready)
        else $error("read taken while busy");
    // PWM pin follows A and B matches only in PWM mode
    a_pwm_set: assert property (compareMatchA[0]
        && !pwmPinOe_n[0] |=> pwmPinOut[0])
        else $error("pwm pin not set");
    a_pwm_clear: assert property (compareMatchB[2]
        && !compareMatchA[2] && !pwmPinOe_n[2] |=> !pwmPinOut[2])
        else $error("pwm pin not cleared");
    a_pwm_idle: assert property (pwmPinOe_n[1] |-> !pwmPinOut[1])
        else $error("pin driven outside pwm");
    a_irq_follow: assert property (matchAIrq != 3'h0 |-> irq)
        else $error("irq missing");
    a_standby_reset: assert property (standby [*2] |=>
        pwmPinOe_n == 3'h7 && matchAIrq == 3'h0)
        else $error("standby left state");
endmodule : timer_mode_match_checker

bind timer_mode_match timer_mode_match_checker timer_mode_match_checker_inst (
    .sys_clk, .srst, .standby, .arvalid, .arready, .rvalid, .rready,
    .rdata, .bvalid, .bready, .bresp, .compareMatchA, .compareMatchB,
    .pwmPinOut, .pwmPinOe_n, .matchAIrq, .irq);

/* bench/timer_mode_match_tb_top.sv */
/* Self-checking bench for timer_mode_match over AXI4-Lite.
   Assumes the encoder model on the channel 2 clock pins. */
`timescale 1ns/1ps
module timer_mode_match_tb_top;
    logic        sys_clk = 1'b0, srst = 1'b1, standby = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rdVal;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic        arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq;
    logic [1:0]  bresp, rresp, rsp;
    logic [2:0]  compareMatchA = 3'h0, compareMatchB = 3'h0, captureA = 3'h0;
    logic [2:0]  aIsCapture = 3'h0, pwmPinOut, pwmPinOe_n, matchAIrq;
    logic        normalTick2 = 1'h0, clearReq2 = 1'h0;
    logic        stepUp = 1'h0, stepDown = 1'h0;
    logic        extClockPinA, extClockPinB, overflowFlagSet2;
    logic [15:0] counterCh2;
    int          failures = 0, checks_done = 0, ovfPulses = 0;
    always #5 sys_clk = ~sys_clk;
    // One-cycle overflow set pulses, counted for the scenarios
    always @(posedge sys_clk) begin
        if (overflowFlagSet2 === 1'b1) begin
            ovfPulses <= ovfPulses + 1;
        end
    end
    timer_mode_match timer_mode_match_inst (
        .sys_clk, .srst, .standby, .awaddr, .awvalid, .awready, .wdata,
        .wstrb(4'h1), .wvalid, .wready, .bresp, .bvalid, .bready, .araddr,
        .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .compareMatchA, .compareMatchB, .captureA, .aIsCapture,
        .normalTick2, .clearReq2, .extClockPinA, .extClockPinB,
        .pwmPinOut, .pwmPinOe_n, .matchAIrq, .counterCh2,
        .overflowFlagSet2, .irq);
    quad_pins_model quad_pins_model_inst (.sys_clk, .stepUp, .stepDown,
        .pinA(extClockPinA), .pinB(extClockPinB));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("CHECK FAILED %0t: got %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        if (failures == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : conclude
    // Both channels offered at once, each dropped when taken; bready
    // comes a cycle after bvalid so the answer has to wait
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int n;
        logic pa, pw;
        n = 0;
        pa = 1'b1;
        pw = 1'b1;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        {awvalid, wvalid} <= 2'h3;
        while (n < 50 && !(bready && bvalid === 1'b1)) begin
            @(posedge sys_clk);
            n++;
            if (pa && awready === 1'b1) begin
                pa = 1'b0;
                awvalid <= 1'b0;
            end
            if (pw && wready === 1'b1) begin
                pw = 1'b0;
                wvalid <= 1'b0;
            end
            if (!pa && !pw && !bready && bvalid === 1'b1) begin
                bready <= 1'b1;
            end
        end
        bready <= 1'b0;
        rsp = bresp;
        if (n >= 50) begin
            failures++;
            conclude();
        end
    endtask : wr
    // rready comes a cycle after rvalid so the answer has to wait
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        int n;
        logic pa;
        n = 0;
        pa = 1'b1;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1'b1;
        while (n < 50 && !(rready && rvalid === 1'b1)) begin
            @(posedge sys_clk);
            n++;
            if (pa && arready === 1'b1) begin
                pa = 1'b0;
                arvalid <= 1'b0;
            end
            if (!pa && !rready && rvalid === 1'b1) begin
                rready <= 1'b1;
            end
        end
        rready <= 1'b0;
        rdVal = rdata;
        rsp = rresp;
        chk(rdVal, e);
        if (n >= 50) begin
            failures++;
            conclude();
        end
    endtask : rdchk
    task automatic pulse(input logic [2:0] ma, mb, ca);
        @(posedge sys_clk);
        {compareMatchA, compareMatchB, captureA} <= {ma, mb, ca};
        @(posedge sys_clk);
        {compareMatchA, compareMatchB, captureA} <= 9'h000;
        repeat (2) @(posedge sys_clk);
    endtask : pulse
    // Normal ticks ride along; two-phase mode must ignore them
    task automatic step(input logic up, input int k);
        repeat (k) begin
            @(posedge sys_clk);
            {stepUp, stepDown, normalTick2} <= {up, !up, 1'b1};
            @(posedge sys_clk);
            {stepUp, stepDown, normalTick2} <= 3'h0;
            repeat (3) @(posedge sys_clk);
        end
    endtask : step
    task automatic t_reset();
        rdchk(8'h00, 32'h98);
        chk(rsp, 2'h0);
        rdchk(8'h04, 32'h88);
        wr(8'h20, 32'hFF);
        chk(rsp, 2'h2);
        rdchk(8'h20, 32'h0);
        chk(rsp, 2'h2);
    endtask : t_reset
    task automatic t_mode();
        wr(8'h00, 32'h0);
        chk(rsp, 2'h0);
        rdchk(8'h00, 32'h98);
        wr(8'h00, 32'hFF);
        rdchk(8'h00, 32'hFF);
        chk(pwmPinOe_n, 3'h0);
        wr(8'h04, 32'h77);
        @(posedge sys_clk);
        standby <= 1'b1;
        repeat (3) @(posedge sys_clk);
        standby <= 1'b0;
        rdchk(8'h00, 32'h98);
        rdchk(8'h04, 32'h88);
        chk(pwmPinOe_n, 3'h7);
    endtask : t_mode
    task automatic t_pwm();
        wr(8'h00, 32'h9F);
        pulse(3'h7, 3'h0, 3'h0);
        chk(pwmPinOut, 3'h7);
        pulse(3'h0, 3'h7, 3'h0);
        chk(pwmPinOut, 3'h0);
        rdchk(8'h04, 32'h8F);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h88);
    endtask : t_pwm
    // Capture on channel 1, late set on channel 0 survives a clear
    task automatic t_flags();
        aIsCapture <= 3'h2;
        pulse(3'h1, 3'h0, 3'h2);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h8B);
        wr(8'h04, 32'h07);
        rdchk(8'h04, 32'h8B);
        pulse(3'h1, 3'h0, 3'h0);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h89);
    endtask : t_flags
    task automatic t_irq();
        wr(8'h04, 32'h11);
        repeat (2) @(posedge sys_clk);
        chk({matchAIrq, irq}, 4'h3);
        wr(8'h04, 32'h01);
        repeat (2) @(posedge sys_clk);
        chk({matchAIrq, irq}, 4'h0);
        rdchk(8'h04, 32'h89);
        wr(8'h04, 32'h0);
        rdchk(8'h04, 32'h88);
    endtask : t_irq
    task automatic t_quad();
        wr(8'h00, 32'hD8);
        step(1'b1, 3);
        rdchk(8'h10, 32'h3);
        step(1'b0, 4);
        rdchk(8'h10, 32'hFFFF);
        rdchk(8'h08, 32'h3);
        chk(ovfPulses, 1);
        chk(irq, 1'b0);
        wr(8'h0C, 32'h1);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b1);
        wr(8'h08, 32'h3);
        repeat (2) @(posedge sys_clk);
        chk(irq, 1'b0);
        wr(8'h00, 32'hF8);
        step(1'b0, 1);
        step(1'b1, 2);
        rdchk(8'h08, 32'h1);
        chk(ovfPulses, 2);
        wr(8'h08, 32'h3);
        step(1'b0, 1);
        rdchk(8'h08, 32'h2);
        chk(ovfPulses, 2);
        @(posedge sys_clk);
        clearReq2 <= 1'b1;
        @(posedge sys_clk);
        clearReq2 <= 1'b0;
        rdchk(8'h10, 32'h0);
        // Normal mode: ticks count up, pin steps are ignored
        wr(8'h00, 32'h98);
        step(1'b0, 2);
        rdchk(8'h10, 32'h2);
    endtask : t_quad
    initial begin
        repeat (10) @(posedge sys_clk);
        srst <= 1'b0;
        t_reset();
        t_mode();
        t_pwm();
        t_flags();
        t_irq();
        t_quad();
        conclude();
    end
endmodule : timer_mode_match_tb_top

/* verilog/quad_count_if.sv */
/*
 * Count pulses from the two-phase decoder to the mode block.
 * Both ends run on sys_clk; each pulse lasts one cycle.
 */
`timescale 1ns/1ps
interface quad_count_if;
    logic up;
    logic down;
    modport src (output up, output down);
    modport dst (input up, input down);
endinterface : quad_count_if

/* verilog/quad_decoder.sv */
/*
 * Two-phase edge decoder for the channel 2 external clock pins.
 * Assumes pins already synchronous to sys_clk; one pulse per edge.
 */
`timescale 1ns/1ps
module quad_decoder (
    input  wire logic   sys_clk,
    input  wire logic   srst,
    input  wire logic   extClockPinA,
    input  wire logic   extClockPinB,
    quad_count_if.src   count
);
    logic prevA;
    logic prevB;

    // Last pin levels, for edge detection
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            prevA <= 1'b0;
            prevB <= 1'b0;
        end else begin
            prevA <= extClockPinA;
            prevB <= extClockPinB;
        end
    end

    // Direction from which pin moved and the other pin's level
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            count.up   <= 1'b0;
            count.down <= 1'b0;
        end else begin
            // Both pins moving at once is ambiguous: no count
            count.up <= ((extClockPinA != prevA) && (extClockPinB == prevB)
                         && (extClockPinA == ~extClockPinB))
                     || ((extClockPinB != prevB) && (extClockPinA == prevA)
                         && (extClockPinB == extClockPinA));
            count.down <= ((extClockPinA != prevA) && (extClockPinB == prevB)
                           && (extClockPinA == extClockPinB))
                       || ((extClockPinB != prevB) && (extClockPinA == prevA)
                           && (extClockPinB == ~extClockPinA));
        end
    end
endmodule : quad_decoder

/* verilog/timer_mode_match.sv */
/*
 * Mode selection, channel 2 counter, PWM pins and compare-A flags
 * of a three-channel timer, with an AXI4-Lite register slave.
 * Assumes compare, capture and clear events come from the channel
 * datapaths as one-cycle pulses synchronous to sys_clk.
 */
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
module timer_mode_match #(
    parameter int COUNT_W = timer_mode_pkg::COUNT_W
) (
    input  wire logic                                  sys_clk,
    input  wire logic                                  srst,
    input  wire logic                                  standby,
    // AXI4-Lite slave
    input  wire logic [timer_mode_pkg::AXI_ADDR_W-1:0] awaddr,
    input  wire logic                                  awvalid,
    output logic                                       awready,
    input  wire logic [31:0]                           wdata,
    input  wire logic [3:0]                            wstrb,
    input  wire logic                                  wvalid,
    output logic                                       wready,
    output logic [1:0]                                 bresp,
    output logic                                       bvalid,
    input  wire logic                                  bready,
    input  wire logic [timer_mode_pkg::AXI_ADDR_W-1:0] araddr,
    input  wire logic                                  arvalid,
    output logic                                       arready,
    output logic [31:0]                                rdata,
    output logic [1:0]                                 rresp,
    output logic                                       rvalid,
    input  wire logic                                  rready,
    // Channel events
    input  wire logic [2:0]                            compareMatchA,
    input  wire logic [2:0]                            compareMatchB,
    input  wire logic [2:0]                            captureA,
    input  wire logic [2:0]                            aIsCapture,
    input  wire logic                                  normalTick2,
    input  wire logic                                  clearReq2,
    input  wire logic                                  extClockPinA,
    input  wire logic                                  extClockPinB,
    // Outputs
    output logic [2:0]                                 pwmPinOut,
    output logic [2:0]                                 pwmPinOe_n,
    output logic [2:0]                                 matchAIrq,
    output logic [COUNT_W-1:0]                         counterCh2,
    output logic                                       overflowFlagSet2,
    output logic                                       irq
);
    localparam int AW = timer_mode_pkg::AXI_ADDR_W;

    // Offset match; used by write and read decode
    function automatic logic isAddr(input logic [AW-1:0] addr,
                                    input logic [7:0]    ofs);
        isAddr = (addr[AW-1:2] == ofs[AW-1:2]);
    endfunction : isAddr

    function automatic logic isMapped(input logic [AW-1:0] addr);
        isMapped = isAddr(addr, timer_mode_pkg::OFS_MODE)
                || isAddr(addr, timer_mode_pkg::OFS_STAT_A)
                || isAddr(addr, timer_mode_pkg::OFS_EVT_STAT)
                || isAddr(addr, timer_mode_pkg::OFS_EVT_MASK)
                || isAddr(addr, timer_mode_pkg::OFS_COUNT2);
    endfunction : isMapped

    logic [7:0]                        timerModeSelect;
    logic [2:0]                        matchAIrqEn;
    logic [2:0]                        matchAFlag;
    logic [2:0]                        clearArmed;
    logic [timer_mode_pkg::EVT_W-1:0]  evtStatus;
    logic [timer_mode_pkg::EVT_W-1:0]  evtMask;
    logic [AW-1:0]                     wAddr;
    logic [31:0]                       wData;
    logic [3:0]                        wStrb;
    logic                              awHeld;
    logic                              wHeld;
    logic                              awTake;
    logic                              wTake;
    logic                              arTake;
    logic                              doWrite;
    logic                              lowLane;
    logic                              wrMode;
    logic                              wrStat;
    logic                              wrEvtStat;
    logic                              wrEvtMask;
    logic                              rdStat;
    logic                              initRegs;
    logic                              twoPhase;
    logic                              ovfOnlySel;
    logic [2:0]                        pwmMode;
    logic [2:0]                        aEvent;
    logic [2:0]                        clearHit;
    logic                              countUp;
    logic                              countDown;
    logic                              overflow2;
    logic                              underflow2;
    logic [7:0]                        statRead;
    logic [31:0]                       readMux;

    quad_count_if quadCount ();

    quad_decoder quad_decoder_inst (
        .sys_clk      (sys_clk),
        .srst         (srst),
        .extClockPinA (extClockPinA),
        .extClockPinB (extClockPinB),
        .count        (quadCount.src)
    );

    // Handshakes and decoded strobes
    assign awTake    = awvalid && awready;
    assign wTake     = wvalid && wready;
    assign arTake    = arvalid && arready;
    assign doWrite   = awHeld && wHeld && !bvalid;
    assign lowLane   = doWrite && wStrb[0];
    assign wrMode    = lowLane && isAddr(wAddr, timer_mode_pkg::OFS_MODE);
    assign wrStat    = lowLane && isAddr(wAddr, timer_mode_pkg::OFS_STAT_A);
    assign wrEvtStat = lowLane && isAddr(wAddr, timer_mode_pkg::OFS_EVT_STAT);
    assign wrEvtMask = lowLane && isAddr(wAddr, timer_mode_pkg::OFS_EVT_MASK);
    assign rdStat    = arTake && isAddr(araddr, timer_mode_pkg::OFS_STAT_A);
    // Standby puts the registers back to their reset state
    assign initRegs  = srst || standby;

    // Mode fields
    assign twoPhase   = timerModeSelect[timer_mode_pkg::MODE_TWO_PHASE];
    assign ovfOnlySel = timerModeSelect[timer_mode_pkg::MODE_OVF_SEL];
    assign pwmMode    = timerModeSelect[timer_mode_pkg::MODE_PWM_LO +: 3];

    // Write address channel; one address held until the write is done
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            awHeld  <= 1'b0;
            wAddr   <= '0;
            awready <= 1'b0;
        end else begin
            if (awTake) begin
                awHeld <= 1'b1;
                wAddr  <= awaddr;
            end else if (doWrite) begin
                awHeld <= 1'b0;
            end
            awready <= !awTake && !(awHeld && !doWrite);
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wHeld  <= 1'b0;
            wData  <= '0;
            wStrb  <= '0;
            wready <= 1'b0;
        end else begin
            if (wTake) begin
                wHeld <= 1'b1;
                wData <= wdata;
                wStrb <= wstrb;
            end else if (doWrite) begin
                wHeld <= 1'b0;
            end
            wready <= !wTake && !(wHeld && !doWrite);
        end
    end

    // Write response; unmapped offsets answer SLVERR
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            bvalid <= 1'b0;
            bresp  <= timer_mode_pkg::RESP_OKAY;
        end else if (doWrite) begin
            bvalid <= 1'b1;
            bresp  <= isMapped(wAddr) ? timer_mode_pkg::RESP_OKAY
                                      : timer_mode_pkg::RESP_SLVERR;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    // Status byte as software sees it, reserved bits forced high
    assign statRead = timer_mode_pkg::STAT_RSVD
                    | {1'b0, matchAIrqEn, 1'b0, matchAFlag};

    // Read data selection
    always_comb begin
        readMux = '0;
        if (isAddr(araddr, timer_mode_pkg::OFS_MODE)) begin
            readMux[7:0] = timerModeSelect | timer_mode_pkg::MODE_RSVD;
        end else if (isAddr(araddr, timer_mode_pkg::OFS_STAT_A)) begin
            readMux[7:0] = statRead;
        end else if (isAddr(araddr, timer_mode_pkg::OFS_EVT_STAT)) begin
            readMux[timer_mode_pkg::EVT_W-1:0] = evtStatus;
        end else if (isAddr(araddr, timer_mode_pkg::OFS_EVT_MASK)) begin
            readMux[timer_mode_pkg::EVT_W-1:0] = evtMask;
        end else if (isAddr(araddr, timer_mode_pkg::OFS_COUNT2)) begin
            readMux[COUNT_W-1:0] = counterCh2;
        end
    end

    // Read channel; answer one cycle after the address is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= timer_mode_pkg::RESP_OKAY;
        end else begin
            arready <= !arTake && (!rvalid || rready);
            if (arTake) begin
                rvalid <= 1'b1;
                rdata  <= readMux;
                rresp  <= isMapped(araddr) ? timer_mode_pkg::RESP_OKAY
                                           : timer_mode_pkg::RESP_SLVERR;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // Mode register; reserved bits held at one whatever is written
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            timerModeSelect <= timer_mode_pkg::MODE_RESET;
        end else if (wrMode) begin
            timerModeSelect <= (wData[7:0] & ~timer_mode_pkg::MODE_RSVD)
                             | timer_mode_pkg::MODE_RSVD;
        end
    end

    // Interrupt enables of the status register
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            matchAIrqEn <= timer_mode_pkg::STAT_RESET[6:4];
        end else if (wrStat) begin
            matchAIrqEn <= wData[timer_mode_pkg::STAT_EN_LO +: 3];
        end
    end

    // Per-channel A flag, its read arming and its PWM pin
    genvar ch;
    generate
        for (ch = 0; ch < 3; ch++) begin : g_chan
            // Event source chosen by the register A configuration
            assign aEvent[ch] = aIsCapture[ch]
                              ? captureA[ch]
                              : compareMatchA[ch];
            // A written 1 never touches the flag
            assign clearHit[ch] = wrStat && clearArmed[ch]
                && !wData[timer_mode_pkg::STAT_FLAG_LO + ch];

            // Set wins over a clear in the same cycle
            always_ff @(posedge sys_clk) begin
                if (initRegs) begin
                    matchAFlag[ch] <= timer_mode_pkg::STAT_RESET[ch];
                end else if (aEvent[ch]) begin
                    matchAFlag[ch] <= 1'b1;
                end else if (clearHit[ch]) begin
                    matchAFlag[ch] <= 1'b0;
                end
            end

            // Armed by a read that saw 1; a new set disarms it
            always_ff @(posedge sys_clk) begin
                if (initRegs) begin
                    clearArmed[ch] <= 1'b0;
                end else if (aEvent[ch] || clearHit[ch]) begin
                    clearArmed[ch] <= 1'b0;
                end else if (rdStat && matchAFlag[ch]) begin
                    clearArmed[ch] <= 1'b1;
                end
            end

            // PWM drive: A match raises, B match lowers
            always_ff @(posedge sys_clk) begin
                if (initRegs) begin
                    pwmPinOut[ch]  <= 1'b0;
                    pwmPinOe_n[ch] <= 1'b1;
                end else begin
                    pwmPinOe_n[ch] <= !pwmMode[ch];
                    if (!pwmMode[ch]) begin
                        pwmPinOut[ch] <= 1'b0;
                    end else if (compareMatchA[ch]) begin
                        pwmPinOut[ch] <= 1'b1;
                    end else if (compareMatchB[ch]) begin
                        pwmPinOut[ch] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    // Count source: the decoder overrides the normal tick
    assign countUp    = twoPhase ? quadCount.up
                                 : normalTick2;
    assign countDown  = twoPhase && quadCount.down;
    assign overflow2  = countUp && (counterCh2 == '1);
    assign underflow2 = countDown && (counterCh2 == '0);

    // Channel 2 counter; external clear still works in two-phase mode
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            counterCh2 <= '0;
        end else if (clearReq2) begin
            counterCh2 <= '0;
        end else if (countUp) begin
            counterCh2 <= counterCh2 + 1'b1;
        end else if (countDown) begin
            counterCh2 <= counterCh2 - 1'b1;
        end
    end

    // Overflow flag setting condition; underflow counts only while MODE_OVF_SEL is clear
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            overflowFlagSet2 <= 1'b0;
        end else begin
            overflowFlagSet2 <= overflow2
                || (underflow2 && !ovfOnlySel);
        end
    end

    // Own event status, write one to clear, set wins
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            evtStatus <= '0;
        end else begin
            evtStatus <= (evtStatus
                & ~(wrEvtStat ? wData[timer_mode_pkg::EVT_W-1:0] : '0))
                | {underflow2, overflow2 || (underflow2 && !ovfOnlySel)};
        end
    end

    // Event mask
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            evtMask <= '0;
        end else if (wrEvtMask) begin
            evtMask <= wData[timer_mode_pkg::EVT_W-1:0];
        end
    end

    // Interrupt lines, one cycle behind the flags
    always_ff @(posedge sys_clk) begin
        if (initRegs) begin
            matchAIrq <= '0;
            irq       <= 1'b0;
        end else begin
            matchAIrq <= matchAFlag & matchAIrqEn;
            irq       <= |(matchAFlag & matchAIrqEn) || |(evtStatus & evtMask);
        end
    end
endmodule : timer_mode_match

/* verilog/timer_mode_pkg.sv */
/*
 * Constants of the timer mode and compare-A status block: register
 * offsets, field positions, reset values and widths.
 * Assumes a 32-bit AXI4-Lite bus whose registers sit on aligned words.
 */
package timer_mode_pkg;
    localparam int          AXI_ADDR_W     = 8;
    localparam int          CHANNELS       = 3;
    localparam int          COUNT_W        = 16;
    localparam int          EVT_W          = 2;
    // Register byte offsets
    localparam logic [7:0]  OFS_MODE       = 8'h00;
    localparam logic [7:0]  OFS_STAT_A     = 8'h04;
    localparam logic [7:0]  OFS_EVT_STAT   = 8'h08;
    localparam logic [7:0]  OFS_EVT_MASK   = 8'h0C;
    localparam logic [7:0]  OFS_COUNT2     = 8'h10;
    // Mode register layout
    localparam logic [7:0]  MODE_RESET     = 8'h98;
    localparam logic [7:0]  MODE_RSVD      = 8'h98;
    localparam int          MODE_TWO_PHASE = 6;
    localparam int          MODE_OVF_SEL   = 5;
    localparam int          MODE_PWM_LO    = 0;
    // Compare-A status register layout
    localparam logic [7:0]  STAT_RESET     = 8'h88;
    localparam logic [7:0]  STAT_RSVD      = 8'h88;
    localparam int          STAT_EN_LO     = 4;
    localparam int          STAT_FLAG_LO   = 0;
    // Own event status bits
    localparam int          EVT_OVF_FLAG   = 0;
    localparam int          EVT_UNDERFLOW  = 1;
    // Bus answers
    localparam logic [1:0]  RESP_OKAY      = 2'h0;
    localparam logic [1:0]  RESP_SLVERR    = 2'h2;
endpackage : timer_mode_pkg
